// ===== design/spmc_top.sv
// spmc_top: system mode state machine with wake handling, fail-safe sleep,
// and an AHB-Lite register slave with sticky event flags and interrupt.
// assumes single-clock operation and synchronous, already filtered inputs.
// Operation
// - reset mode enables supplies, inits modules, waits core supply stable
// - reset mode follows power-on and every wake from sleep
// - active mode enables every module
// - writing mode control command starts requested low-power transition
// - stop keeps mcu powered; wakes on lin, monitor, enabled gpio
// - cyclic bit then stop: wake on timer or enabled lin/monitor/gpio
// - sleep cuts mcu supply; wakes on lin, monitor or cyclic timer
// - cyclic sleep still honours enabled lin and monitor wakes
// - retained registers keep contents through sleep
// - five watchdog or supply failures force sleep, monitor wake, 1 s cycle
// - external reset ignored while in sleep
// - slow-down lowers cpu clock, lin and low-side drivers stay usable
// - equal-priority wakes, first starts wake, all latched until cleared
// - monitor and gpio wake edges selectable rise, fall or both
// - monitor is default wake source after power-on only
`timescale 1ns/100ps
`default_nettype none
module spmc_top
  import spmc_pkg::*;
#(
  parameter int unsigned FAILSAFE_CYCLES = FAILSAFE_CYC,
  parameter int unsigned CLEAN_CYCLES    = 1024,
  parameter int unsigned GPIO_W          = 4
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hsel,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              linWake,
  input  wire logic              hvMonitorWakeInput,
  input  wire logic [GPIO_W-1:0] gpioWake,
  input  wire logic              coreSupplyRailOk,
  input  wire logic              watchdogFail,
  input  wire logic              supplyFail,
  input  wire logic              extReset,
  output logic                   suppliesEn,
  output logic                   modulesRst,
  output logic                   mcuPowerEn,
  output logic                   mcuClockRun,
  output logic                   mcuClockSlow,
  output logic                   lowSideGateDriversEn,
  output logic                   linTrxEn,
  output logic                   irq
);

  if (GPIO_W < 1 || GPIO_W > 8) begin : gChkGpioW
    $error("spmc_top: GPIO_W must be 1..8");
  end
  if (CLEAN_CYCLES < 1 || FAILSAFE_CYCLES < 1) begin : gChkCycles
    $error("spmc_top: CLEAN_CYCLES and FAILSAFE_CYCLES must be >= 1");
  end

  typedef enum logic [2:0] {ST_RESET, ST_ACTIVE, ST_STOP, ST_SLEEP} spmc_mode_e;

  function automatic logic edgeHit(input logic cur, input logic prev, input logic [1:0] sel);
    edgeHit = (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
  endfunction : edgeHit

  spmc_mode_e  mode_r;
  logic [3:0]  modeCtrl_r;
  logic [1:0]  pendCmd_r;
  logic [7:0]  wakeCfg_r;
  logic [31:0] cycCfg_r;
  logic [31:0] cycCnt_r;
  logic        cycOn_r;
  logic        failSafe_r;
  logic [2:0]  wdFails_r;
  logic [2:0]  supFails_r;
  logic [31:0] cleanCnt_r;
  logic [2:0]  stableCnt_r;
  logic        monPrev_r;
  logic [GPIO_W-1:0] gpioPrev_r;
  logic [EV_W-1:0] irqStat_r;
  logic [EV_W-1:0] irqMask_r;
  logic [31:0] retain0_r;
  logic [31:0] retain1_r;
  logic        porDone_r;

  // bus address phase capture
  logic        dWr_r;
  logic        dRd_r;
  logic [7:0]  dAddr_r;
  logic        addrPhase;
  assign addrPhase = hsel & hready & htrans[1];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dWr_r   <= 1'b0;
      dRd_r   <= 1'b0;
      dAddr_r <= 8'h00;
    end else if (hready) begin
      dWr_r   <= addrPhase & hwrite;
      dRd_r   <= addrPhase & ~hwrite;
      dAddr_r <= haddr[7:0];
    end
  end

  // zero-wait slave, always okay
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // wake event detection
  logic evLin, evMon, evGpio, evCyc, evFail;
  logic wakeStop, wakeSleep, cmdWrite;
  logic wdTrip, supTrip;
  assign evLin  = linWake & wakeCfg_r[WK_EN_LIN];
  assign evMon  = (wakeCfg_r[WK_EN_MON] | failSafe_r) &
                  edgeHit(hvMonitorWakeInput, monPrev_r,
                          wakeCfg_r[WK_MON_EDGE_LSB +: 2]);
  assign evGpio = wakeCfg_r[WK_EN_GPIO] &
                  (|((gpioWake & ~gpioPrev_r & {GPIO_W{wakeCfg_r[WK_GPIO_EDGE_LSB]}}) |
                     (~gpioWake & gpioPrev_r & {GPIO_W{wakeCfg_r[WK_GPIO_EDGE_LSB+1]}})));
  assign evCyc  = cycOn_r & (cycCnt_r == 32'h0) & (mode_r == ST_STOP || mode_r == ST_SLEEP);
  assign wdTrip  = watchdogFail & (wdFails_r == FAIL_LIMIT - 3'h1);
  assign supTrip = supplyFail & (supFails_r == FAIL_LIMIT - 3'h1);
  assign evFail = (mode_r == ST_ACTIVE) & (wdTrip | supTrip);
  assign wakeStop  = evLin | evMon | evGpio | evCyc;
  assign wakeSleep = evLin | evMon | evCyc;
  assign cmdWrite  = dWr_r & (dAddr_r == OFS_MODE_CTRL);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // start from the pin level so leaving reset gives no false edge
      monPrev_r  <= hvMonitorWakeInput;
      gpioPrev_r <= gpioWake;
    end else begin
      monPrev_r  <= hvMonitorWakeInput;
      gpioPrev_r <= gpioWake;
    end
  end

  // mode state machine
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_r      <= ST_RESET;
      stableCnt_r <= 3'h0;
      pendCmd_r   <= CMD_NONE;
      failSafe_r  <= 1'b0;
    end else begin
      unique case (mode_r)
        ST_RESET: begin
          if (extReset || !coreSupplyRailOk) begin
            stableCnt_r <= 3'h0;
          end else if (stableCnt_r == 3'(RESET_HOLD_CYC - 1)) begin
            mode_r      <= ST_ACTIVE;
            stableCnt_r <= 3'h0;
          end else begin
            stableCnt_r <= stableCnt_r + 3'h1;
          end
        end
        ST_ACTIVE: begin
          if (extReset) begin
            mode_r <= ST_RESET;
          end else if (evFail) begin
            mode_r     <= ST_SLEEP;
            failSafe_r <= 1'b1;
          end else if (pendCmd_r == CMD_STOP) begin
            mode_r    <= ST_STOP;
            pendCmd_r <= CMD_NONE;
          end else if (pendCmd_r == CMD_SLEEP) begin
            mode_r    <= ST_SLEEP;
            pendCmd_r <= CMD_NONE;
          end
        end
        ST_STOP: begin
          if (extReset) mode_r <= ST_RESET;
          else if (wakeStop) mode_r <= ST_ACTIVE;
        end
        ST_SLEEP: begin
          if (wakeSleep) begin
            mode_r     <= ST_RESET;
            failSafe_r <= 1'b0;
          end
        end
        default: mode_r <= ST_RESET;
      endcase
      // a fresh command outranks clearing the one just taken
      if (cmdWrite && hwdata[MC_CMD_LSB +: 2] != CMD_NONE)
        pendCmd_r <= hwdata[MC_CMD_LSB +: 2];
    end
  end

  // cyclic wake timer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cycCnt_r <= 32'h0;
      cycOn_r  <= 1'b0;
    end else if (mode_r == ST_ACTIVE) begin
      cycOn_r  <= evFail | modeCtrl_r[MC_CYC_BIT];
      cycCnt_r <= evFail ? 32'(FAILSAFE_CYCLES - 1) : cycCfg_r;
    end else if (mode_r == ST_STOP || mode_r == ST_SLEEP) begin
      if (cycCnt_r != 32'h0) cycCnt_r <= cycCnt_r - 32'h1;
    end else begin
      cycOn_r <= 1'b0;
    end
  end

  // consecutive failure counters
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wdFails_r  <= 3'h0;
      supFails_r <= 3'h0;
      cleanCnt_r <= 32'h0;
    end else if (evFail) begin
      wdFails_r  <= 3'h0;
      supFails_r <= 3'h0;
      cleanCnt_r <= 32'h0;
    end else if (mode_r == ST_ACTIVE) begin
      if (watchdogFail || supplyFail) begin
        cleanCnt_r <= 32'h0;
        if (watchdogFail) wdFails_r <= wdFails_r + 3'h1;
        if (supplyFail) supFails_r <= supFails_r + 3'h1;
      end else if (cleanCnt_r == 32'(CLEAN_CYCLES - 1)) begin
        wdFails_r  <= 3'h0;
        supFails_r <= 3'h0;
        cleanCnt_r <= 32'h0;
      end else begin
        cleanCnt_r <= cleanCnt_r + 32'h1;
      end
    end
  end

  // software registers; retained words survive sleep, cleared only by sys_rst
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      modeCtrl_r <= 4'h0;
      wakeCfg_r  <= WAKE_CFG_RST;
      cycCfg_r   <= CYC_CFG_RST;
      irqMask_r  <= '0;
      retain0_r  <= 32'h0;
      retain1_r  <= 32'h0;
      porDone_r  <= 1'b0;
    end else begin
      porDone_r <= 1'b1;
      if (dWr_r) begin
        unique case (dAddr_r)
          OFS_MODE_CTRL: modeCtrl_r <= {hwdata[MC_SLOW_BIT], hwdata[MC_CYC_BIT], 2'h0};
          OFS_WAKE_CFG:  wakeCfg_r  <= hwdata[7:0];
          OFS_CYC_CFG:   cycCfg_r   <= hwdata;
          OFS_IRQ_MASK:  irqMask_r  <= hwdata[EV_W-1:0];
          OFS_RETAIN0:   retain0_r  <= hwdata;
          OFS_RETAIN1:   retain1_r  <= hwdata;
          default: ;
        endcase
      end
    end
  end

  // sticky wake flags, write one to clear, set wins over clear
  logic [EV_W-1:0] evVec;
  assign evVec = {evFail, evCyc, evGpio, evMon, evLin};
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqStat_r <= '0;
    end else begin
      irqStat_r <= (irqStat_r & ~((dWr_r && dAddr_r == OFS_IRQ_STAT) ?
                                   hwdata[EV_W-1:0] : '0)) | evVec;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) irq <= 1'b0;
    else irq <= |(irqStat_r & irqMask_r);
  end

  // read mux
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hrdata <= 32'h0;
    end else if (addrPhase && !hwrite) begin
      unique case (haddr[7:0])
        OFS_MODE_CTRL: hrdata <= {28'h0, modeCtrl_r[3:2], pendCmd_r};
        OFS_WAKE_CFG:  hrdata <= {24'h0, wakeCfg_r};
        OFS_CYC_CFG:   hrdata <= cycCfg_r;
        OFS_STATUS:    hrdata <= {24'h0, wdFails_r, failSafe_r, cycOn_r, mode_r};
        OFS_IRQ_STAT:  hrdata <= {27'h0, irqStat_r};
        OFS_IRQ_MASK:  hrdata <= {27'h0, irqMask_r};
        OFS_RETAIN0:   hrdata <= retain0_r;
        OFS_RETAIN1:   hrdata <= retain1_r;
        default:       hrdata <= 32'h0;
      endcase
    end
  end

  // power and clock outputs per mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      suppliesEn           <= 1'b0;
      modulesRst           <= 1'b1;
      mcuPowerEn           <= 1'b0;
      mcuClockRun          <= 1'b0;
      mcuClockSlow         <= 1'b0;
      lowSideGateDriversEn <= 1'b0;
      linTrxEn             <= 1'b0;
    end else begin
      suppliesEn   <= (mode_r != ST_SLEEP);
      modulesRst   <= (mode_r == ST_RESET);
      mcuPowerEn   <= (mode_r != ST_SLEEP);
      mcuClockRun  <= (mode_r == ST_ACTIVE);
      mcuClockSlow <= (mode_r == ST_ACTIVE) & modeCtrl_r[MC_SLOW_BIT];
      lowSideGateDriversEn <= (mode_r == ST_ACTIVE);
      linTrxEn     <= (mode_r == ST_ACTIVE);
    end
  end

endmodule : spmc_top
`default_nettype wire

// ===== design/spmc_pkg.sv
// spmc_pkg: register map, field positions, reset values and timing counts
// for the system power mode controller.
// assumes a 250 MHz system clock and 32-bit AHB-Lite register access.
package spmc_pkg;

  localparam int unsigned CLK_HZ = 250_000_000;

  // register byte offsets
  localparam logic [7:0] OFS_MODE_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAKE_CFG  = 8'h04;
  localparam logic [7:0] OFS_CYC_CFG   = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;
  localparam logic [7:0] OFS_RETAIN0   = 8'h18;
  localparam logic [7:0] OFS_RETAIN1   = 8'h1c;

  // mode control fields
  localparam int MC_CMD_LSB  = 0;   // 2-bit command
  localparam int MC_CYC_BIT  = 2;   // cyclic wake-up select
  localparam int MC_SLOW_BIT = 3;   // mcu slow-down

  localparam logic [1:0] CMD_NONE  = 2'h0;
  localparam logic [1:0] CMD_STOP  = 2'h1;
  localparam logic [1:0] CMD_SLEEP = 2'h2;

  // wake config: per-source enable and edge select
  localparam int WK_EN_LIN  = 0;
  localparam int WK_EN_MON  = 1;
  localparam int WK_EN_GPIO = 2;
  localparam int WK_MON_EDGE_LSB  = 4;  // 2 bits: 1 rise, 2 fall, 3 both
  localparam int WK_GPIO_EDGE_LSB = 6;
  localparam logic [7:0] WAKE_CFG_RST = 8'h12;  // monitor enabled, rising edge

  // wake/event flag positions (irq status and irq mask layout)
  localparam int EV_LIN   = 0;
  localparam int EV_MON   = 1;
  localparam int EV_GPIO  = 2;
  localparam int EV_CYC   = 3;
  localparam int EV_FAIL  = 4;
  localparam int EV_W     = 5;

  localparam logic [2:0] FAIL_LIMIT = 3'h5;

  // timing: fail-safe cyclic period and default cyclic period
  localparam int unsigned FAILSAFE_MS = 1000;
  localparam int unsigned FAILSAFE_CYC = FAILSAFE_MS * (CLK_HZ / 1000);
  localparam int unsigned CYC_CFG_RST = 32'h0000_1000;
  localparam int unsigned RESET_HOLD_CYC = 4;  // stable samples before active

endpackage : spmc_pkg

// ===== test/spmc_top_chk.sv
// spmc_top_chk: port-level checks of the mode sequencer outputs
// assumes it is bound to spmc_top and sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module spmc_top_chk (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        coreSupplyRailOk,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        suppliesEn,
  input wire logic        modulesRst,
  input wire logic        mcuPowerEn,
  input wire logic        mcuClockRun,
  input wire logic        mcuClockSlow,
  input wire logic        lowSideGateDriversEn,
  input wire logic        linTrxEn,
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // checked through reset itself, so it carries its own disable
  AST_RST_STATE: assert property (disable iff (1'b0) sys_rst |=> modulesRst && !mcuPowerEn && !irq)
    else $error("outputs wrong after reset");
  AST_RAIL_BEFORE_RUN: assert property ($fell(modulesRst) |-> $past(coreSupplyRailOk, 2) && $past(coreSupplyRailOk, 3))
    else $error("left reset mode without stable core rail");
  AST_ACTIVE_ALL_ON: assert property ($fell(modulesRst) |-> suppliesEn && mcuPowerEn && linTrxEn)
    else $error("active mode without all modules on");
  AST_WAKE_VIA_RESET: assert property ($rose(suppliesEn) |-> modulesRst)
    else $error("supplies came up outside reset mode");
  AST_MCU_NEEDS_SUPPLY: assert property (mcuPowerEn |-> suppliesEn)
    else $error("mcu powered without supplies");
  AST_SLEEP_MCU_OFF: assert property ($fell(suppliesEn) |-> !mcuPowerEn && !mcuClockRun)
    else $error("supplies off but mcu still on");
  AST_SLOW_KEEPS_LIN: assert property (mcuClockSlow |-> mcuClockRun && linTrxEn && lowSideGateDriversEn)
    else $error("slow-down lost lin or low-side drivers");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or error response");
  // flags are sticky: irq may only drop three edges after a write address phase
  AST_IRQ_HELD_TILL_CLEAR: assert property ($fell(irq) |-> $past(hsel && htrans[1] && hwrite, 3))
    else $error("interrupt dropped without a register write");
endmodule : spmc_top_chk
bind spmc_top spmc_top_chk chk (.clock, .sys_rst, .coreSupplyRailOk, .hsel, .htrans, .hwrite,
  .hrdata, .hreadyout,
  .hresp, .suppliesEn, .modulesRst, .mcuPowerEn, .mcuClockRun, .mcuClockSlow,
  .lowSideGateDriversEn, .linTrxEn, .irq);
`default_nettype wire

// ===== test/spmc_wake_model.sv
// spmc_wake_model: core rail, wake sources and watchdog seen by the sequencer
// assumes one-cycle request pulses from the bench, lin held as a level
`timescale 1ns/100ps
`default_nettype none
module spmc_wake_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       suppliesEn,
  input  wire logic [3:0] req,
  output logic            linWake,
  output logic            hvMonitorWakeInput,
  output logic [3:0]      gpioWake,
  output logic            coreSupplyRailOk,
  output logic            watchdogFail,
  output logic            supplyFail
);
  logic [2:0] railCnt;
  // rail collapses whenever supplies drop, never kinder than real
  always_ff @(posedge clock) begin
    if (sys_rst || !suppliesEn)
      railCnt <= 3'h0;
    else if (railCnt != 3'h7)
      railCnt <= railCnt + 3'h1;
  end
  assign coreSupplyRailOk = (railCnt == 3'h7);
  always_ff @(posedge clock) begin
    linWake      <= req[0];
    watchdogFail <= req[3];
    supplyFail   <= 1'b0;
    if (sys_rst)
      hvMonitorWakeInput <= 1'b0;
    else if (req[1])
      hvMonitorWakeInput <= ~hvMonitorWakeInput;
    if (sys_rst)
      gpioWake <= 4'h0;
    else if (req[2])
      gpioWake <= gpioWake ^ 4'h1;
  end
endmodule : spmc_wake_model
`default_nettype wire

// ===== test/test_system_power_mode_control.sv
// test_system_power_mode_control: mode, wake, fail-safe and irq scenarios
// assumes zero-wait slave and a partner model for rail and wake sources
`timescale 1ns/100ps
`default_nettype none
module test_system_power_mode_control;
  import spmc_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, hwrite = 1'b0, extReset = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seen, rnd;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  req = 4'h0, gpioWake;
  logic hready, hreadyout, hresp, linWake, hvMonitorWakeInput, coreSupplyRailOk;
  logic watchdogFail, supplyFail, suppliesEn, modulesRst, mcuPowerEn, mcuClockRun;
  logic mcuClockSlow, lowSideGateDriversEn, linTrxEn, irq;
  logic [31:0] expQ[$];
  int n_fail = 0, compares = 0, i;
  logic [7:0] cfgT[3] = '{8'h01, 8'h32, 8'h44};
  event rdEv;
  assign hready = hreadyout;
  spmc_top #(.FAILSAFE_CYCLES(100), .CLEAN_CYCLES(16), .GPIO_W(4)) DUT (.clock, .sys_rst,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hsel(1'b1), .hready, .hrdata,
    .hreadyout, .hresp, .linWake, .hvMonitorWakeInput, .gpioWake, .coreSupplyRailOk,
    .watchdogFail, .supplyFail, .extReset, .suppliesEn, .modulesRst, .mcuPowerEn,
    .mcuClockRun, .mcuClockSlow, .lowSideGateDriversEn, .linTrxEn, .irq);
  spmc_wake_model partner (.clock, .sys_rst, .suppliesEn, .req, .linWake,
    .hvMonitorWakeInput, .gpioWake, .coreSupplyRailOk, .watchdogFail, .supplyFail);
  initial begin
    forever #2 clock = ~clock;
  end
  task automatic give_verdict;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic cmpPin(input string n, input logic e, input logic g);
    cmp(n, {31'h0, e}, {31'h0, g});
  endtask : cmpPin
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    expQ.push_back(e & m);
    bus(a, 1'b0, 32'h0, q);
    seen = q & m;
    -> rdEv;
  endtask : rd
  task automatic waitMode(input logic [2:0] m);
    logic [31:0] q;
    for (int k = 0; k < 400; k++) begin
      bus(OFS_STATUS, 1'b0, 32'h0, q);
      if (q[2:0] === m)
        break;
    end
    rd(OFS_STATUS, 32'h7, {29'h0, m});
  endtask : waitMode
  task automatic pulse(input int b, input int n);
    @(posedge clock);
    req[b] <= 1'b1;
    repeat (n) @(posedge clock);
    req[b] <= 1'b0;
  endtask : pulse
  // reset mode is short, so it is caught on the pin rather than by polling
  task automatic wakeViaReset;
    for (int k = 0; k < 2000 && modulesRst !== 1'b1; k++)
      @(posedge clock);
    cmpPin("modulesRst", 1'b1, modulesRst);
    waitMode(3'h1);
  endtask : wakeViaReset
  task automatic flag(input int b);
    rd(OFS_IRQ_STAT, 32'h1 << b, 32'h1 << b);
    cmpPin("irq", 1'b1, irq);
    wr(OFS_IRQ_STAT, 32'h1f);
    rd(OFS_IRQ_STAT, 32'h1f, 32'h0);
    cmpPin("irq", 1'b0, irq);
  endtask : flag
  initial begin
    forever begin
      @rdEv;
      cmp("register read", expQ.pop_front(), seen);
    end
  end
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    give_verdict();
  end
  initial begin
    void'($urandom(34));
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rd(OFS_WAKE_CFG, 32'hff, {24'h0, WAKE_CFG_RST});
    rd(OFS_CYC_CFG, 32'hffffffff, CYC_CFG_RST);
    rd(8'h40, 32'hffffffff, 32'h0);
    waitMode(3'h1);
    cmpPin("mcuPowerEn", 1'b1, mcuPowerEn);
    cmpPin("linTrxEn", 1'b1, linTrxEn);
    wr(OFS_IRQ_MASK, 32'h1f);
    // lin level, monitor on both edges, gpio on rising edge
    for (i = 0; i < 3; i++) begin
      wr(OFS_WAKE_CFG, {24'h0, cfgT[i]});
      wr(OFS_MODE_CTRL, {30'h0, CMD_STOP});
      waitMode(3'h2);
      cmpPin("mcuPowerEn", 1'b1, mcuPowerEn);
      pulse(i, (i == 0) ? 4 : 1);
      waitMode(3'h1);
      flag(i);
    end
    rnd = $urandom;
    wr(OFS_RETAIN0, rnd);
    wr(OFS_WAKE_CFG, 32'h22);
    wr(OFS_MODE_CTRL, {30'h0, CMD_SLEEP});
    waitMode(3'h3);
    cmpPin("mcuPowerEn", 1'b0, mcuPowerEn);
    @(posedge clock) extReset <= 1'b1;
    repeat (10) @(posedge clock);
    rd(OFS_STATUS, 32'h7, 32'h3);
    @(posedge clock) extReset <= 1'b0;
    pulse(1, 1);
    wakeViaReset();
    rd(OFS_RETAIN0, 32'hffffffff, rnd);
    flag(1);
    wr(OFS_MODE_CTRL, 32'h4);
    wr(OFS_CYC_CFG, 32'd60);
    wr(OFS_MODE_CTRL, 32'h6);
    waitMode(3'h3);
    wakeViaReset();
    flag(3);
    wr(OFS_MODE_CTRL, 32'h5);
    waitMode(3'h2);
    waitMode(3'h1);
    flag(3);
    wr(OFS_MODE_CTRL, 32'h0);
    repeat (4) pulse(3, 1);
    repeat (40) @(posedge clock);
    pulse(3, 1);
    rd(OFS_STATUS, 32'he7, 32'h21);
    repeat (5) pulse(3, 1);
    waitMode(3'h3);
    rd(OFS_STATUS, 32'h17, 32'h13);
    rd(OFS_WAKE_CFG, 32'h2, 32'h2);
    wakeViaReset();
    rd(OFS_IRQ_STAT, 32'h10, 32'h10);
    wr(OFS_MODE_CTRL, 32'h8);
    repeat (4) @(posedge clock);
    cmpPin("mcuClockSlow", 1'b1, mcuClockSlow);
    cmpPin("linTrxEn", 1'b1, linTrxEn);
    cmpPin("lowSideGateDriversEn", 1'b1, lowSideGateDriversEn);
    // sleep asked for while stopped is held until the wake is done
    wr(OFS_MODE_CTRL, {30'h0, CMD_STOP});
    waitMode(3'h2);
    wr(OFS_MODE_CTRL, {30'h0, CMD_SLEEP});
    rd(OFS_MODE_CTRL, 32'h3, {30'h0, CMD_SLEEP});
    rd(OFS_STATUS, 32'h7, 32'h2);
    pulse(1, 1);
    pulse(1, 1);
    waitMode(3'h3);
    give_verdict();
  end
endmodule : test_system_power_mode_control
`default_nettype wire
